// *** src/readout_defs.svh ***
// Register map, field positions, reset values and sizes of the readout configuration block.
`ifndef READOUT_DEFS_SVH
`define READOUT_DEFS_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define ADDR_W              8
`define REG_W               16
`define BLACK_LEVEL_ADDR    8'h80
`define GENERAL_CFG_ADDR    8'h81
`define IDLE_WORD_ADDR      8'h82
`define CAL_STATUS_ADDR     8'hA0

// ----------------------------------------------------------------------------
// Reset values and writable bit masks
// ----------------------------------------------------------------------------
`define BLACK_LEVEL_RST     16'h4008
`define GENERAL_CFG_RST     16'hC001
`define IDLE_WORD_RST       16'h03A6
`define BLACK_LEVEL_WMASK   16'h87FF
`define GENERAL_CFG_WMASK   16'h27FF
`define IDLE_WORD_WMASK     16'h03FF
`define ZERO_REG            16'h0000

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TARGET_MSB          7
`define TARGET_LSB          0
`define SAMPLES_MSB         10
`define SAMPLES_LSB         8
`define AUTO_CAL_BIT        0
`define MAN_OFFSET_MSB      9
`define MAN_OFFSET_LSB      1
`define OFFSET_DEC_BIT      10
`define NARROW_BIT          13
`define CAL_VALID_BIT       15
`define IDLE_WORD_MSB       9
`define IDLE_WORD_LSB       0

// ----------------------------------------------------------------------------
// Data path sizes
// ----------------------------------------------------------------------------
`define WORD_W              10
`define NARROW_W            8
`define CHANNELS            2
`define FIFO_DEPTH          4
`define WIN_SHIFT           4
`define ACC_W               17
`define SAMPLE_CNT_W        8
`define CALC_W              13

`endif

// *** src/readout_pkg.sv ***
// Types shared by the readout configuration block.
`include "readout_defs.svh"

package readout_pkg;

	typedef logic [`WORD_W-1:0] word_t;
	typedef enum logic [2:0] {CAL_OFF = 3'h1, CAL_GATHER = 3'h2, CAL_LOCKED = 3'h4} cal_state_t;
	typedef logic [`REG_W-1:0]  reg_t;
	typedef logic [`ADDR_W-1:0] addr_t;

endpackage

// *** src/word_fifo.sv ***
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ns

module word_fifo
#(
	parameter int WIDTH = 22,
	parameter int DEPTH = 4
)
(
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic             wr;
	logic             rd;

	assign wr       = in_valid && in_ready;
	assign rd       = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
		begin
			bump = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
		end
	endfunction

	always_comb
	begin
		next_count = count;
		if (wr && !rd)
			next_count = count + CNT_W'(1);
		else if (rd && !wr)
			next_count = count - CNT_W'(1);
	end

	always_ff @(posedge clk)
	begin
		if (wr)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end
		else
		begin
			if (wr)
				wr_ptr <= bump(wr_ptr);
			if (rd)
				rd_ptr <= bump(rd_ptr);
			count     <= next_count;
			// Flags are registered so that both ready and valid come straight from flip-flops.
			in_ready  <= (next_count != CNT_W'(DEPTH));
			out_valid <= (next_count != '0);
		end
	end

endmodule

// *** src/readout_config.sv ***
// Black-level calibration, output word format and idle alignment word for the readout path.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`include "readout_defs.svh"

// Behaviour
// - Calibration averages two to the power of the sample-count field black samples.
// - Auto calibration applies when its enable bit is 1; bypassed at 0; resets 1.
// - With auto calibration off the nine-bit manual offset corrects; resets to zero.
// - Manual offset is added when direction bit is 0, subtracted when 1.
// - Word-width bit 0 gives 10-bit words, 1 gives 8-bit words; resets 0.
// - In 8-bit mode window identification is shifted four cycles later.
// - In idle the programmable ten-bit alignment word goes on every channel, only its eight top bits in 8-bit mode; resets 0x3A6.
// - Output black level is driven toward the eight-bit target, which resets to 8.
module readout_config
	import readout_pkg::*;
(
	input  wire logic                          CLOCK,
	input  wire logic                          NRST,
	input  wire logic [`ADDR_W-1:0]            REG_ADDR,
	input  wire logic [`REG_W-1:0]             REG_WDATA,
	input  wire logic                          REG_WR,
	input  wire logic                          REG_RD,
	output logic      [`REG_W-1:0]             REG_RDATA,
	input  wire logic [`CHANNELS*`WORD_W-1:0]  PIX_DATA,
	input  wire logic                          PIX_BLACK,
	input  wire logic                          PIX_WIN_ID,
	input  wire logic                          PIX_VALID,
	output logic                               PIX_READY,
	input  wire logic                          IDLE_MODE,
	input  wire logic                          OUT_READY,
	output logic      [`CHANNELS*`WORD_W-1:0]  DATA_OUT,
	output logic                               DATA_VALID,
	output logic                               WIN_ID,
	output logic                               NARROW_WORD_SEL
);

	localparam int FIFO_W = `CHANNELS * `WORD_W + 2;

	// ------------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------------
	reg_t black_level_config;
	reg_t general_readout_config;
	reg_t idle_alignment_word;
	reg_t cal_status;

	logic                     auto_cal;
	logic [2:0]               sample_sel;
	logic [7:0]               target_level;
	logic [8:0]               man_offset;
	logic                     offset_dec;
	logic                     narrow;
	word_t                    idle_word;

	assign auto_cal     = general_readout_config[`AUTO_CAL_BIT];
	assign man_offset   = general_readout_config[`MAN_OFFSET_MSB:`MAN_OFFSET_LSB];
	assign offset_dec   = general_readout_config[`OFFSET_DEC_BIT];
	assign narrow       = general_readout_config[`NARROW_BIT];
	assign sample_sel   = black_level_config[`SAMPLES_MSB:`SAMPLES_LSB];
	assign target_level = black_level_config[`TARGET_MSB:`TARGET_LSB];
	assign idle_word    = idle_alignment_word[`IDLE_WORD_MSB:`IDLE_WORD_LSB];

	// Only writable bits take the written value; reserved bits hold their reset value.
	function automatic reg_t masked_write(input reg_t old_val, input reg_t new_val, input reg_t wmask);
		begin
			masked_write = (old_val & ~wmask) | (new_val & wmask);
		end
	endfunction

	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
		begin
			black_level_config     <= `BLACK_LEVEL_RST;
			general_readout_config <= `GENERAL_CFG_RST;
			idle_alignment_word    <= `IDLE_WORD_RST;
		end
		else if (REG_WR)
		begin
			case (REG_ADDR)
				`BLACK_LEVEL_ADDR:
					black_level_config <= masked_write(black_level_config, REG_WDATA, `BLACK_LEVEL_WMASK);
				`GENERAL_CFG_ADDR:
					general_readout_config <= masked_write(general_readout_config, REG_WDATA,
						`GENERAL_CFG_WMASK);
				`IDLE_WORD_ADDR:
					idle_alignment_word <= masked_write(idle_alignment_word, REG_WDATA, `IDLE_WORD_WMASK);
				default:
				begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
			REG_RDATA <= `ZERO_REG;
		else if (REG_RD)
		begin
			case (REG_ADDR)
				`BLACK_LEVEL_ADDR: REG_RDATA <= black_level_config;
				`GENERAL_CFG_ADDR: REG_RDATA <= general_readout_config;
				`IDLE_WORD_ADDR:   REG_RDATA <= idle_alignment_word;
				`CAL_STATUS_ADDR:  REG_RDATA <= cal_status;
				default:           REG_RDATA <= `ZERO_REG;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Input buffer
	// ------------------------------------------------------------------------
	logic [FIFO_W-1:0] fifo_out;
	logic              fifo_valid;
	logic              fifo_pop_ready;
	logic              pop;
	logic              pop_black;
	logic              pop_win;
	word_t             pop_ch0;

	// Idle mode or a stalled receiver leaves words in the buffer, which backs up to PIX_READY.
	assign fifo_pop_ready = OUT_READY && !IDLE_MODE;
	assign pop            = fifo_valid && fifo_pop_ready;
	assign pop_black      = fifo_out[FIFO_W-1];
	assign pop_win        = fifo_out[FIFO_W-2];
	assign pop_ch0        = fifo_out[`WORD_W-1:0];

	word_fifo
	#(
		.WIDTH (FIFO_W),
		.DEPTH (`FIFO_DEPTH)
	)
	u_fifo
	(
		.clk       (CLOCK),
		.nrst      (NRST),
		.in_data   ({PIX_BLACK, PIX_WIN_ID, PIX_DATA}),
		.in_valid  (PIX_VALID),
		.in_ready  (PIX_READY),
		.out_data  (fifo_out),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop_ready)
	);

	// ------------------------------------------------------------------------
	// Automatic black-level estimate
	// ------------------------------------------------------------------------
	logic [`ACC_W-1:0]        acc;
	logic [`ACC_W-1:0]        acc_sum;
	logic [`SAMPLE_CNT_W-1:0] sample_cnt;
	word_t                    black_est;
	logic                     est_valid;
	cal_state_t               cal_state;
	cal_state_t               next_cal_state;
	logic                     take_black;
	logic                     last_sample;

	function automatic logic [`SAMPLE_CNT_W-1:0] total_samples(input logic [2:0] sel);
		begin
			total_samples = `SAMPLE_CNT_W'(1) << sel;
		end
	endfunction

	assign acc_sum     = acc + `ACC_W'(pop_ch0);
	assign take_black  = pop && pop_black;
	assign last_sample = (sample_cnt + `SAMPLE_CNT_W'(1)) >= total_samples(sample_sel);
	assign est_valid   = (cal_state == CAL_LOCKED);

	// Black samples come from channel 0 only; one estimate serves every channel.
	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
		begin
			acc        <= '0;
			sample_cnt <= '0;
			black_est  <= '0;
		end
		else if (!auto_cal)
		begin
			acc        <= '0;
			sample_cnt <= '0;
		end
		else if (take_black)
		begin
			if (last_sample)
			begin
				black_est  <= word_t'(acc_sum >> sample_sel);
				acc        <= '0;
				sample_cnt <= '0;
			end
			else
			begin
				acc        <= acc_sum;
				sample_cnt <= sample_cnt + `SAMPLE_CNT_W'(1);
			end
		end
	end

	// ------------------------------------------------------------------------
	// Calibration sequencing
	// ------------------------------------------------------------------------
	// The estimate survives bypass, so re-enabling corrects with the old one until a new round ends.
	always_comb
	begin
		next_cal_state = cal_state;
		case (cal_state)
			CAL_OFF:
			begin
				if (auto_cal && take_black && last_sample)
					next_cal_state = CAL_LOCKED;
				else if (auto_cal)
					next_cal_state = CAL_GATHER;
			end
			CAL_GATHER:
			begin
				if (!auto_cal)
					next_cal_state = CAL_OFF;
				else if (take_black && last_sample)
					next_cal_state = CAL_LOCKED;
			end
			CAL_LOCKED:
			begin
				if (!auto_cal)
					next_cal_state = CAL_OFF;
			end
			default:
				next_cal_state = CAL_OFF;
		endcase
	end

	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
			cal_state <= CAL_OFF;
		else
			cal_state <= next_cal_state;
	end

	// Status word: estimate-valid flag at the top, current estimate in the low bits.
	function automatic reg_t status_word(input logic valid, input word_t est);
		reg_t s;
		begin
			s                 = `ZERO_REG;
			s[`CAL_VALID_BIT] = valid;
			s[`WORD_W-1:0]    = est;
			status_word       = s;
		end
	endfunction

	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
			cal_status <= `ZERO_REG;
		else
			cal_status <= status_word(est_valid, black_est);
	end

	// ------------------------------------------------------------------------
	// Correction and output format
	// ------------------------------------------------------------------------
	function automatic word_t correct(input word_t pix);
		logic signed [`CALC_W-1:0] v;
		begin
			v = $signed({3'b000, pix});
			if (auto_cal)
				v = v - $signed({3'b000, black_est}) + $signed({5'b00000, target_level});
			else if (offset_dec)
				v = v - $signed({4'b0000, man_offset});
			else
				v = v + $signed({4'b0000, man_offset});
			if (v < 0)
				correct = '0;
			else if (v > $signed({3'b000, {`WORD_W{1'b1}}}))
				correct = {`WORD_W{1'b1}};
			else
				correct = word_t'(v);
		end
	endfunction

	// Narrow mode keeps the eight most significant bits, right aligned in the lane.
	function automatic word_t format_word(input word_t w, input logic nrw);
		begin
			format_word = nrw ? word_t'(w[`WORD_W-1:`WORD_W-`NARROW_W]) : w;
		end
	endfunction

	logic [`CHANNELS*`WORD_W-1:0] next_data;

	always_comb
	begin
		next_data = '0;
		for (int ch = 0; ch < `CHANNELS; ch++)
		begin
			if (pop)
				next_data[ch*`WORD_W +: `WORD_W] = format_word(correct(fifo_out[ch*`WORD_W +: `WORD_W]), narrow);
			else
				next_data[ch*`WORD_W +: `WORD_W] = format_word(idle_word, narrow);
		end
	end

	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
		begin
			DATA_OUT        <= {`CHANNELS{word_t'(`IDLE_WORD_RST)}};
			DATA_VALID      <= 1'b0;
			NARROW_WORD_SEL <= 1'b0;
		end
		else
		begin
			// Between pixel words the lanes carry the alignment word so the receiver can lock.
			DATA_OUT        <= next_data;
			DATA_VALID      <= pop;
			NARROW_WORD_SEL <= narrow;
		end
	end

	// ------------------------------------------------------------------------
	// Window identification timing
	// ------------------------------------------------------------------------
	logic [`WIN_SHIFT-1:0] win_pipe;
	logic                  next_win;

	assign next_win = pop && pop_win;

	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
		begin
			win_pipe <= '0;
			WIN_ID   <= 1'b0;
		end
		else
		begin
			win_pipe <= {win_pipe[`WIN_SHIFT-2:0], next_win};
			// A mode change while a window mark is in flight may drop or repeat that mark.
			WIN_ID   <= narrow ? win_pipe[`WIN_SHIFT-1] : next_win;
		end
	end

endmodule

// *** verif/readout_config_checker.sv ***
// Port-level assertions for the readout configuration block.
`timescale 1ns/1ns
`include "readout_defs.svh"

module readout_config_checker
(
	input wire logic               CLOCK,
	input wire logic               NRST,
	input wire logic [`ADDR_W-1:0] REG_ADDR,
	input wire logic [`REG_W-1:0]  REG_WDATA,
	input wire logic               REG_WR,
	input wire logic               REG_RD,
	input wire logic [`REG_W-1:0]  REG_RDATA,
	input wire logic               IDLE_MODE,
	input wire logic               OUT_READY,
	input wire logic [19:0]        DATA_OUT,
	input wire logic               DATA_VALID,
	input wire logic               WIN_ID,
	input wire logic               NARROW_WORD_SEL
);
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (!NRST);

	// ---------------------------------------
	// Properties
	// ---------------------------------------
	sequence s_idle_write;
		REG_WR && REG_ADDR == 8'h82 ##1 !NARROW_WORD_SEL ##1 !NARROW_WORD_SEL && !DATA_VALID;
	endsequence
	sequence s_narrow_held;
		NARROW_WORD_SEL [*3];
	endsequence

	property p_width_follow;
		REG_WR && REG_ADDR == 8'h81 |-> ##2 NARROW_WORD_SEL == $past(REG_WDATA[13], 2);
	endproperty
	a_width_follow: assert property (p_width_follow) else $error("width select not taken");

	property p_narrow_lanes;
		s_narrow_held |-> DATA_OUT[9:8] == 2'b00 && DATA_OUT[19:18] == 2'b00;
	endproperty
	a_narrow_lanes: assert property (p_narrow_lanes) else $error("narrow lane has high bits");

	property p_lanes_alike;
		!DATA_VALID |-> DATA_OUT[19:10] == DATA_OUT[9:0];
	endproperty
	a_lanes_alike: assert property (p_lanes_alike) else $error("idle lanes differ");

	property p_idle_word;
		s_idle_write |-> DATA_OUT[9:0] == $past(REG_WDATA[9:0], 2);
	endproperty
	a_idle_word: assert property (p_idle_word) else $error("idle word not sent");

	property p_pop_cause;
		DATA_VALID |-> $past(OUT_READY) && !$past(IDLE_MODE);
	endproperty
	a_pop_cause: assert property (p_pop_cause) else $error("word sent while idle or stalled");

	property p_win_wide;
		WIN_ID && !NARROW_WORD_SEL |-> DATA_VALID;
	endproperty
	a_win_wide: assert property (p_win_wide) else $error("wide window mark off its word");

	property p_win_narrow;
		WIN_ID && NARROW_WORD_SEL |-> $past(DATA_VALID, 4);
	endproperty
	a_win_narrow: assert property (p_win_narrow) else $error("narrow window mark not delayed");

	property p_reserved_cfg;
		REG_RD && REG_ADDR == 8'h81 |=> REG_RDATA[15:14] == 2'b11 && REG_RDATA[12:11] == 2'b00;
	endproperty
	a_reserved_cfg: assert property (p_reserved_cfg) else $error("reserved bits changed");
endmodule

bind readout_config readout_config_checker readout_config_checker_i
(
	.CLOCK(CLOCK), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
	.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IDLE_MODE(IDLE_MODE), .OUT_READY(OUT_READY),
	.DATA_OUT(DATA_OUT), .DATA_VALID(DATA_VALID), .WIN_ID(WIN_ID), .NARROW_WORD_SEL(NARROW_WORD_SEL)
);

// *** verif/lane_receiver.sv ***
// Far-side receiver model that locks on the idle word and paces its ready.
`timescale 1ns/1ns

module lane_receiver
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [19:0] lanes,
	input  wire logic        valid,
	input  wire logic [9:0]  train,
	input  wire logic        slow,
	output logic             ready,
	output logic             locked
);
	logic [1:0] pace;

	// Pixel words are refused until the alignment word has been seen on both lanes.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			locked <= 1'b0;
		else if (!valid && lanes == {train, train})
			locked <= 1'b1;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			pace <= 2'h0;
		else
			pace <= pace + 2'h1;
	end

	// A slow receiver takes one cycle in four, so words back up in the buffer.
	assign ready = locked && (!slow || pace == 2'h0);
endmodule

// *** verif/readout_config_tb.sv ***
// Self-checking bench for the readout configuration block.
`timescale 1ns/1ns

module readout_config_tb import readout_pkg::*;;
	logic        CLOCK = 1'b0;
	logic        NRST = 1'b0;
	addr_t       REG_ADDR = 8'h00;
	reg_t        REG_WDATA = 16'h0000;
	logic        REG_WR = 1'b0;
	logic        REG_RD = 1'b0;
	reg_t        REG_RDATA;
	logic [19:0] PIX_DATA = 20'h00000;
	logic        PIX_BLACK = 1'b0;
	logic        PIX_WIN_ID = 1'b0;
	logic        PIX_VALID = 1'b0;
	logic        PIX_READY;
	logic        IDLE_MODE = 1'b1;
	logic        OUT_READY;
	logic [19:0] DATA_OUT;
	logic        DATA_VALID;
	logic        WIN_ID;
	logic        NARROW_WORD_SEL;
	logic        slow = 1'b0;
	logic [9:0]  train = 10'h3A6;
	logic [20:0] seen[$];
	logic [20:0] want[$];
	logic [31:0] seed = 32'h00000010;
	int          err_count = 0;
	int          total_checks = 0;
	int          since = 0;
	int          win_gap = 0;

	always #5 CLOCK = ~CLOCK;

	readout_config readout_config_i (.CLOCK(CLOCK), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PIX_DATA(PIX_DATA), .PIX_BLACK(PIX_BLACK),
		.PIX_WIN_ID(PIX_WIN_ID), .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY), .IDLE_MODE(IDLE_MODE),
		.OUT_READY(OUT_READY), .DATA_OUT(DATA_OUT), .DATA_VALID(DATA_VALID), .WIN_ID(WIN_ID),
		.NARROW_WORD_SEL(NARROW_WORD_SEL));
	lane_receiver lane_receiver_i (.clk(CLOCK), .nrst(NRST), .lanes(DATA_OUT), .valid(DATA_VALID),
		.train(train), .slow(slow), .ready(OUT_READY), .locked());

	// Also measures how many cycles a window mark trails the last emitted word.
	always @(posedge CLOCK)
	begin
		if (WIN_ID === 1'b1)
			win_gap = (DATA_VALID === 1'b1) ? 0 : since;
		since = (DATA_VALID === 1'b1) ? 1 : since + 1;
		if (DATA_VALID === 1'b1)
			seen.push_back({WIN_ID, DATA_OUT});
	end

	// ---------------------------------------
	// Helpers
	// ---------------------------------------
	function automatic logic [9:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[9:0];
	endfunction

	function automatic logic [9:0] clampw(input int v);
		return (v < 0) ? 10'h000 : (v > 1023) ? 10'h3FF : 10'(v);
	endfunction

	task automatic check(input string what, input logic [20:0] exp, input logic [20:0] got);
		total_checks++;
		if (exp !== got)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input addr_t a, input reg_t d);
		@(posedge CLOCK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLOCK);
		REG_WR <= 1'b0;
	endtask

	task automatic rd(input addr_t a, input reg_t exp);
		@(posedge CLOCK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLOCK);
		REG_RD <= 1'b0;
		@(negedge CLOCK);
		check("read data", 21'(exp), 21'(REG_RDATA));
	endtask

	task automatic push(input logic [19:0] d, input logic blk, input logic w);
		@(posedge CLOCK);
		PIX_DATA <= d;
		PIX_BLACK <= blk;
		PIX_WIN_ID <= w;
		PIX_VALID <= 1'b1;
		do @(posedge CLOCK); while (PIX_READY !== 1'b1);
		PIX_VALID <= 1'b0;
	endtask

	// Waits for as many words as expected, then compares them in order.
	task automatic compare_all(input string what);
		int n = 0;
		while (seen.size() < want.size() && n < 200)
		begin
			@(posedge CLOCK);
			n++;
		end
		check("word count", 21'(want.size()), 21'(seen.size()));
		foreach (want[i])
			if (i < seen.size())
				check(what, want[i], seen[i]);
		want.delete();
		seen.delete();
		$display("test %s done", what);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		#300000;
		err_count++;
		conclude();
	end

	initial
	begin
		logic [9:0] p, q, o, b, m;
		logic [7:0] t;
		logic       d;
		int         k, n;
		repeat (8) @(posedge CLOCK);
		NRST <= 1'b1;
		rd(8'h80, 16'h4008);
		rd(8'h81, 16'hC001);
		rd(8'h82, 16'h03A6);
		rd(8'h90, 16'h0000);
		check("reset idle", {1'b0, 10'h3A6, 10'h3A6}, {1'b0, DATA_OUT});
		wr(8'h81, 16'hFFFF);
		rd(8'h81, 16'hE7FF);
		wr(8'h82, 16'hFFFF);
		rd(8'h82, 16'h03FF);
		wr(8'h81, 16'hC000);
		train = rnd();
		wr(8'h82, {6'h00, train});
		repeat (3) @(posedge CLOCK);
		check("idle word", {1'b0, train, train}, {1'b0, DATA_OUT});
		IDLE_MODE <= 1'b0;
		for (k = 0; k < 8; k++)
		begin
			d = ~k[0];
			o = (k < 2) ? 10'h1FF : rnd() & 10'h1FF;
			p = (k < 2) ? {10{k[0]}} : rnd();
			q = rnd();
			slow = k[2];
			wr(8'h81, {5'h18, d, o[8:0], 1'b0});
			push({q, p}, 1'b0, k[1]);
			want.push_back({k[1], clampw(d ? q - o : q + o), clampw(d ? int'(p) - int'(o) : p + o)});
			compare_all("manual");
		end
		for (k = 1; k < 8; k += 3)
		begin
			b = rnd() & 10'h0FF;
			m = rnd() & 10'h03F;
			t = 8'(rnd());
			wr(8'h81, 16'hC000);
			wr(8'h80, {5'h08, 3'(k), t});
			wr(8'h81, 16'hC001);
			for (n = 0; n < (1 << k); n++)
				push({10'h000, (n < (1 << (k - 1))) ? b : b + (m << 1)}, 1'b1, 1'b0);
			repeat (24) @(posedge CLOCK);
			seen.delete();
			p = rnd();
			push({p, p}, 1'b0, 1'b0);
			want.push_back({1'b0, {2{clampw(int'(p) - int'(b + m) + int'(t))}}});
			compare_all("auto");
		end
		wr(8'h81, 16'hE000);
		IDLE_MODE <= 1'b1;
		repeat (3) @(posedge CLOCK);
		@(negedge CLOCK);
		check("narrow select", 21'h1, 21'(NARROW_WORD_SEL));
		check("narrow idle", {3'h0, train[9:2], 2'h0, train[9:2]}, {1'b0, DATA_OUT});
		IDLE_MODE <= 1'b0;
		p = rnd();
		push({p, ~p}, 1'b0, 1'b1);
		want.push_back({3'h0, p[9:2], 2'h0, ~p[9:2]});
		compare_all("narrow");
		repeat (8) @(posedge CLOCK);
		check("window lag", 21'h4, 21'(win_gap));
		wr(8'h81, 16'hC000);
		IDLE_MODE <= 1'b1;
		n = 0;
		@(posedge CLOCK);
		PIX_DATA <= 20'h00000;
		PIX_WIN_ID <= 1'b0;
		PIX_VALID <= 1'b1;
		repeat (10)
		begin
			@(posedge CLOCK);
			if (PIX_READY === 1'b1)
			begin
				want.push_back(21'(n));
				n++;
				PIX_DATA <= 20'(n);
			end
		end
		PIX_VALID <= 1'b0;
		check("buffered words", 21'h4, 21'(n));
		slow = 1'b1;
		IDLE_MODE <= 1'b0;
		compare_all("buffer");
		conclude();
	end
endmodule
